/* core/psr_pkg.sv */
// constants for the potentiometer serial read-back block
// What this block and its host do
// R01: read back tap register or any slot
// R02: data changes on falling serial clock edge
// R03: read data appears only in next frame
// R04: 1010 slot slot 00 reads that slot
// R05: 1100 x x 00 reads the tap register
// R06: mode bit ends byte one, tap MSB-first
// R07: host follows a read with nop or read
// R08: store finishes within two milliseconds
// R09: host sends exactly 24 clocks per frame
// R10: host waits store time after such commands
// R11: command byte is opcode, slot, channel
// R12: asleep only wake-up is accepted
// R13: read frame end loads output shift word
package psr_pkg;

    // frame shape
    localparam int FRAME_BITS = 24;
    localparam int CMD_BITS   = 8;
    localparam int TAP_BITS   = 8;
    localparam int WORD_BITS  = 9;
    localparam int NUM_SLOTS  = 4;
    localparam int CNT_BITS   = 5;

    // field positions inside the command byte
    localparam int OPC_MSB  = 7;
    localparam int OPC_LSB  = 4;
    localparam int SLOT_MSB = 3;
    localparam int SLOT_LSB = 2;
    localparam int CHAN_MSB = 1;
    localparam int CHAN_LSB = 0;

    // opcodes
    localparam logic [3:0] OPC_NO_OPERATION = 4'h0;
    localparam logic [3:0] OPC_WAKE         = 4'h1;
    localparam logic [3:0] OPC_PROG_VALUE   = 4'h2;
    localparam logic [3:0] OPC_PROG_TAP     = 4'h3;
    localparam logic [3:0] OPC_SLEEP        = 4'h8;
    localparam logic [3:0] OPC_SOFT_RESET   = 4'h9;
    localparam logic [3:0] OPC_READ_SLOT    = 4'hA;
    localparam logic [3:0] OPC_LOAD_TAP     = 4'hB;
    localparam logic [3:0] OPC_READ_TAP     = 4'hC;
    localparam logic [1:0] CHAN_OWN         = 2'h0;

    // reset values
    localparam logic [FRAME_BITS-1:0] OUT_WORD_RST = 24'h000000;
    localparam logic [CMD_BITS-1:0]   CMD_RST      = 8'h00;

    // store time
    localparam int CORE_CLK_HZ   = 40_000_000;
    localparam int STORE_TIME_MS = 2;
    localparam int STORE_CYCLES  = STORE_TIME_MS * (CORE_CLK_HZ / 1000);
    localparam int TMR_BITS      = 17;

endpackage

/* core/psr_pot_spi_readback.sv */
// read-back path of the potentiometer serial command port
`timescale 1ns/1ps
`default_nettype none

module psr_pot_spi_readback #(
    parameter int STORE_CYC = psr_pkg::STORE_CYCLES
) (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rstn,
    input  wire logic                        i_spi_sclk,
    input  wire logic                        i_spi_cs_n,
    input  wire logic                        i_spi_sdi,
    output var  logic                        o_spi_sdo,
    output var  logic                        o_spi_sdo_oe,
    input  wire logic [psr_pkg::TAP_BITS-1:0] i_tap_register,
    input  wire logic                        i_buffer_mode_bit,
    input  wire logic [psr_pkg::WORD_BITS-1:0] i_nonvolatile_slot [psr_pkg::NUM_SLOTS],
    output var  logic                        o_sleep,
    output var  logic                        o_store_busy,
    output var  logic                        o_cmd_pulse,
    output var  logic [psr_pkg::CMD_BITS-1:0] o_cmd_byte
);
    import psr_pkg::*;

    // frame timeline, as seen from this block:
    //   chip select falls  - counters leave reset, the output pin shows zero
    //   rises 1..8         - the command byte is shifted in, msb first
    //   rises 9..24        - data bytes of the frame, unused on this path
    //   falls 1..23        - the word prepared by the previous frame leaves
    //   rise 24            - the command is frozen and a toggle announces it
    //   chip select rises  - frame-local state clears again
    // the core sees the toggle a few of its own cycles later, decodes the
    // frozen byte and prepares the word for the next frame; the host must
    // keep chip select high long enough for that to land, because the link
    // side reads the prepared word without a handshake of its own
    //
    // limitation: a frame shorter than the full length leaves no trace,
    // and a longer one only counts up to the full length, so a host that
    // sends too few clocks loses the command, while extra clocks never shift it

    // link domain: everything below up to the crossing runs on the serial clock

    // frame-local state clears while chip select is high, so a stopped
    // clock between frames leaves nothing half done
    logic                    frame_rst_n;
    logic [CNT_BITS-1:0]     rise_cnt_ff;
    logic [CNT_BITS-1:0]     fall_cnt_ff;
    logic [CMD_BITS-1:0]     shift_in_ff;
    logic [CMD_BITS-1:0]     cmd_ff;
    logic                    frame_tgl_ff;
    logic                    sdo_ff;
    logic [CNT_BITS-1:0]     out_idx;

    // core domain
    logic                    tgl_s1_ff;
    logic                    tgl_s2_ff;
    logic                    tgl_s3_ff;
    logic                    tgl_stable_ff;
    logic                    frame_evt;
    logic [3:0]              opcode;
    logic [1:0]              slot_sel;
    logic [1:0]              chan_sel;
    logic                    own_chan;
    logic                    is_read_slot;
    logic                    is_read_tap;
    logic                    starts_store;
    logic                    accepted;
    logic                    awake_ff;
    logic [FRAME_BITS-1:0]   out_word_ff;
    logic [FRAME_BITS-1:0]   nxt_out_word;
    logic [TMR_BITS-1:0]     store_tmr_ff;
    logic                    store_busy_ff;
    logic                    cmd_pulse_ff;
    logic [CMD_BITS-1:0]     cmd_byte_ff;

    assign frame_rst_n = i_rstn & ~i_spi_cs_n;

    // ------------------------------------------------------------------
    // link side, rising edge: count clocks and collect the command byte
    // ------------------------------------------------------------------

    // rising edge counter saturates at the frame length; longer frames
    // are outside the protocol and simply stop counting
    always_ff @(posedge i_spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rise_cnt_ff <= '0;
        end else if (rise_cnt_ff != CNT_BITS'(FRAME_BITS)) begin
            rise_cnt_ff <= rise_cnt_ff + 1'b1;
        end
    end

    // serial input is sampled on the rising edge, first bit is the msb
    always_ff @(posedge i_spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            shift_in_ff <= CMD_RST;
        end else if (rise_cnt_ff < CNT_BITS'(CMD_BITS)) begin
            shift_in_ff <= {shift_in_ff[CMD_BITS-2:0], i_spi_sdi};
        end
    end

    // the command byte is taken on the last clock of a full frame only;
    // it survives chip select going high so the core can read it later
    always_ff @(posedge i_spi_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_ff       <= CMD_RST;
            frame_tgl_ff <= 1'b0;
        end else if (rise_cnt_ff == CNT_BITS'(FRAME_BITS - 1)) begin
            cmd_ff       <= shift_in_ff;           // R11
            frame_tgl_ff <= ~frame_tgl_ff;         // R13
        end
    end

    // ------------------------------------------------------------------
    // link side, falling edge: shift the read-back word out
    // ------------------------------------------------------------------

    // bit 23 of the frame sits in the command slot and is always zero,
    // which the cleared flop already shows when chip select falls
    assign out_idx = (fall_cnt_ff < CNT_BITS'(FRAME_BITS - 1)) ?
                     CNT_BITS'(FRAME_BITS - 2) - fall_cnt_ff : '0;

    always_ff @(negedge i_spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fall_cnt_ff <= '0;
        end else if (fall_cnt_ff != CNT_BITS'(FRAME_BITS)) begin
            fall_cnt_ff <= fall_cnt_ff + 1'b1;
        end
    end

    // out_word_ff belongs to the core but only changes after a frame has
    // ended, so it is quiet for the whole of the next frame
    always_ff @(negedge i_spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sdo_ff <= 1'b0;
        end else if (fall_cnt_ff < CNT_BITS'(FRAME_BITS - 1)) begin
            sdo_ff <= out_word_ff[out_idx];        // R02 R03
        end else begin
            sdo_ff <= 1'b0;
        end
    end

    // the pin is driven only inside a frame
    assign o_spi_sdo    = sdo_ff;
    assign o_spi_sdo_oe = ~i_spi_cs_n;             // R13

    // ------------------------------------------------------------------
    // crossing: frame-done toggle into the core clock
    // ------------------------------------------------------------------

    // three stages; a change counts once the second and third agree,
    // the first stage feeds nothing but the second
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
        end else begin
            tgl_s1_ff <= frame_tgl_ff;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tgl_stable_ff <= 1'b0;
        end else if (tgl_s2_ff == tgl_s3_ff) begin
            tgl_stable_ff <= tgl_s3_ff;
        end
    end

    assign frame_evt = (tgl_s2_ff == tgl_s3_ff) && (tgl_s3_ff != tgl_stable_ff);

    // ------------------------------------------------------------------
    // core side: decode the finished command
    // ------------------------------------------------------------------

    // cmd_ff is held until the next full frame, far longer than the
    // crossing takes, so reading it here is safe
    assign opcode   = cmd_ff[OPC_MSB:OPC_LSB];     // R11
    assign slot_sel = cmd_ff[SLOT_MSB:SLOT_LSB];   // R11
    assign chan_sel = cmd_ff[CHAN_MSB:CHAN_LSB];   // R11
    assign own_chan = (chan_sel == CHAN_OWN);

    // read decode: the opcode must match and the channel must be ours;
    // a read aimed at another channel answers with zeros
    function automatic logic is_read_of(input logic [3:0] opc,
                                        input logic [3:0] want,
                                        input logic       mine);
        return (opc == want) && mine;
    endfunction

    assign is_read_slot = is_read_of(opcode, OPC_READ_SLOT, own_chan);   // R04
    assign is_read_tap  = is_read_of(opcode, OPC_READ_TAP, own_chan);    // R05

    // commands after which the host has to leave the store time; the
    // timer is only a busy indication, nothing here waits on it
    function automatic logic needs_store_time(input logic [3:0] opc);
        logic hit;
        hit = 1'b0;
        case (opc)
            OPC_READ_TAP,
            OPC_READ_SLOT,
            OPC_PROG_VALUE,
            OPC_PROG_TAP,
            OPC_LOAD_TAP: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    assign starts_store = needs_store_time(opcode);

    // a finished frame is heard only while awake, or when it is the
    // wake-up itself; the pulse, byte and timer logic use this one decode so that a
    // refused frame leaves no trace on the pulse, the byte or the timer
    function automatic logic is_heard(input logic awake, input logic [3:0] opc);
        return awake || (opc == OPC_WAKE);
    endfunction

    assign accepted = frame_evt && is_heard(awake_ff, opcode);   // R12

    // sleep state: entered at reset, by soft reset and by sleep, and
    // only the wake-up command is heard while asleep
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            awake_ff <= 1'b0;                      // R12
        end else if (frame_evt) begin
            if (opcode == OPC_WAKE) begin
                awake_ff <= 1'b1;                  // R12
            end else if (awake_ff &&
                         (opcode == OPC_SLEEP || opcode == OPC_SOFT_RESET)) begin
                awake_ff <= 1'b0;                  // R12
            end
        end
    end

    // selected value framed as: command slot zero, seven zeros, mode bit,
    // then the eight tap bits msb first
    always_comb begin
        nxt_out_word = OUT_WORD_RST;
        if (awake_ff && is_read_slot) begin
            nxt_out_word[WORD_BITS-1:0] = i_nonvolatile_slot[slot_sel];        // R01 R04 R06
        end else if (awake_ff && is_read_tap) begin
            nxt_out_word[WORD_BITS-1:0] = {i_buffer_mode_bit, i_tap_register}; // R01 R05 R06
        end
    end

    // every finished frame replaces the word, so data is offered in the
    // following frame only and a second readout shows zeros
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_word_ff <= OUT_WORD_RST;
        end else if (frame_evt) begin
            out_word_ff <= nxt_out_word;           // R03 R13
        end
    end

    // store timer; busy lasts the store time after the last accepted store command, so a second one while busy stretches it
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            store_tmr_ff  <= '0;
            store_busy_ff <= 1'b0;
        end else if (accepted && starts_store) begin
            store_tmr_ff  <= TMR_BITS'(STORE_CYC - 1);  // R08
            store_busy_ff <= 1'b1;
        end else if (store_tmr_ff != '0) begin
            store_tmr_ff  <= store_tmr_ff - 1'b1;       // R08
        end else begin
            store_busy_ff <= 1'b0;
        end
    end

    // accepted command byte handed on to the rest of the device; the byte
    // moves only together with the pulse, so a refused frame sent while
    // asleep cannot leave a stale opcode for a later consumer to act on
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_pulse_ff <= 1'b0;
            cmd_byte_ff  <= CMD_RST;
        end else begin
            cmd_pulse_ff <= accepted;              // R12
            if (accepted) begin
                cmd_byte_ff <= cmd_ff;
            end
        end
    end

    assign o_sleep      = ~awake_ff;
    assign o_store_busy = store_busy_ff;
    assign o_cmd_pulse  = cmd_pulse_ff;
    assign o_cmd_byte   = cmd_byte_ff;

endmodule

`default_nettype wire

/* dv/psr_host_model.sv */
// host serial master model: clock idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module psr_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end
    // n rises msb first; sdo taken just ahead of each fall, where it changes next
    task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx     = 24'h000000;
        o_cs_n = 1'b0;
        #10;
        for (int i = 0; i < n; i++) begin
            o_sdi = tx[23-i];
            #7.5 o_sclk = 1'b1;
            #7.5 rx[23-i] = i_sdo;
            o_sclk = 1'b0;
        end
        #10 o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // released line must not keep the last bit
    endtask
endmodule
`default_nettype wire

/* dv/psr_readback_checker.sv */
// port assertions for the serial read-back block
`timescale 1ns/1ps
`default_nettype none
module psr_readback_checker #(
    parameter int STORE_CYC = 20
) (
    input wire logic                        i_core_clk,
    input wire logic                        i_rstn,
    input wire logic                        i_spi_cs_n,
    input wire logic                        o_spi_sdo,
    input wire logic                        o_spi_sdo_oe,
    input wire logic                        o_sleep,
    input wire logic                        o_store_busy,
    input wire logic                        o_cmd_pulse,
    input wire logic [psr_pkg::CMD_BITS-1:0] o_cmd_byte
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // length of the current busy stretch, for the upper store time bound
    logic [31:0] busy_run;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_run <= '0;
        end else if (o_store_busy) begin
            busy_run <= busy_run + 32'h1;
        end else begin
            busy_run <= '0;
        end
    end
    chk_busy_max_len: assert property (busy_run <= STORE_CYC)
        else $error("store busy longer than the store time");
    chk_oe_follows_cs: assert property (o_spi_sdo_oe == !i_spi_cs_n)
        else $error("sdo enable does not follow select");
    chk_sdo_idle_low: assert property (i_spi_cs_n |-> !o_spi_sdo)
        else $error("sdo driven outside a frame");
    chk_pulse_single: assert property (o_cmd_pulse |=> !o_cmd_pulse)
        else $error("command pulse longer than one cycle");
    chk_sleep_at_start: assert property ($rose(i_rstn) |-> o_sleep)
        else $error("not asleep after reset");
    chk_busy_min_len: assert property ($rose(o_store_busy) |-> o_store_busy[*8])
        else $error("store busy too short");
    chk_store_when_awake: assert property ($rose(o_store_busy) |-> !o_sleep)
        else $error("store started while asleep");
    chk_byte_with_pulse: assert property ($changed(o_cmd_byte) |-> o_cmd_pulse)
        else $error("command byte moved without a pulse");
    chk_sleep_by_cmd: assert property ($changed(o_sleep) |-> o_cmd_pulse || $past(o_cmd_pulse))
        else $error("sleep state moved without a command");
endmodule
bind psr_pot_spi_readback psr_readback_checker #(.STORE_CYC(STORE_CYC)) u_chk (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_spi_cs_n(i_spi_cs_n),
    .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe), .o_sleep(o_sleep),
    .o_store_busy(o_store_busy), .o_cmd_pulse(o_cmd_pulse), .o_cmd_byte(o_cmd_byte));
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the serial read-back block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psr_pkg::*;
    localparam int SIM_STORE = 20;
    logic                 i_core_clk, i_rstn, sclk, cs_n, sdi, sdo, oe, sleep, busy, pulse, mode, seen;
    logic [TAP_BITS-1:0]  tap;
    logic [WORD_BITS-1:0] slot [NUM_SLOTS];
    logic [CMD_BITS-1:0]  cmd_byte;
    logic [23:0]          rx;
    int                   mismatches, samples_checked, busy_cycles;
    psr_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));
    psr_pot_spi_readback #(.STORE_CYC(SIM_STORE)) u_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
        .o_spi_sdo_oe(oe), .i_tap_register(tap), .i_buffer_mode_bit(mode),
        .i_nonvolatile_slot(slot), .o_sleep(sleep), .o_store_busy(busy),
        .o_cmd_pulse(pulse), .o_cmd_byte(cmd_byte));
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // 40 cycles cover decode, the select gap and the whole shortened store time
    task automatic xfer(input logic [7:0] cmd, input int n);
        @(posedge i_core_clk);
        #2;
        u_host.frame({cmd, 16'h0000}, n, rx);
        seen = 1'b0;
        busy_cycles = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge i_core_clk);
            #2;
            if (pulse === 1'b1) seen = 1'b1;
            if (busy === 1'b1) busy_cycles++;
        end
    endtask
    task automatic t_asleep;
        check("sleep", 24'h1, {23'h0, sleep});
        check("oe idle", 24'h0, {23'h0, oe});
        xfer(8'hC0, 24);
        check("pulse", 24'h0, {23'h0, seen});
        check("cmd asleep", 24'h0, {16'h0, cmd_byte});
        check("busy asleep", 24'h0, 24'(busy_cycles));
        xfer(8'h00, 24);
        check("data", 24'h0, rx);
        xfer(8'h10, 24);
        check("sleep", 24'h0, {23'h0, sleep});
        $display("test asleep done");
    endtask
    task automatic t_tap;
        xfer(8'hCC, 24);
        check("pulse", 24'h1, {23'h0, seen});
        check("cmd", 24'hCC, {16'h0, cmd_byte});
        check("busy", 24'(SIM_STORE), 24'(busy_cycles));
        check("data", 24'h0, rx);
        xfer(8'h00, 24);
        check("tap", {15'h0, mode, tap}, rx);
        xfer(8'h00, 24);
        check("again", 24'h0, rx);
        xfer(8'hC1, 24);
        xfer(8'h00, 24);
        check("channel", 24'h0, rx);
        $display("test tap done");
    endtask
    // back-to-back reads: each frame carries the previous slot
    task automatic t_slots;
        for (int s = 0; s <= NUM_SLOTS; s++) begin
            xfer((s < NUM_SLOTS) ? {4'hA, s[1:0], 2'b00} : 8'h00, 24);
            if (s > 0) check("slot", {15'h0, slot[s-1]}, rx);
        end
        xfer(8'hB4, 24);
        check("load busy", 24'(SIM_STORE), 24'(busy_cycles));
        xfer(8'hC0, 23);
        check("short", 24'h0, {23'h0, seen});
        xfer(8'h80, 24);
        check("sleep", 24'h1, {23'h0, sleep});
        xfer(8'h10, 24);
        xfer(8'h95, 24);
        check("soft reset", 24'h1, {23'h0, sleep});
        $display("test slots done");
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    initial begin
        #300000;
        mismatches++;
        close_out();
    end
    initial begin
        mismatches = 0;
        samples_checked = 0;
        i_rstn = 1'b0;
        tap = 8'hA5;
        mode = 1'b1;
        slot[0] = 9'h1C3;
        slot[1] = 9'h03C;
        slot[2] = 9'h1FF;
        slot[3] = 9'h081;
        repeat (12) @(posedge i_core_clk);
        #2 i_rstn = 1'b1;
        t_asleep();
        t_tap();
        t_slots();
        close_out();
    end
endmodule
`default_nettype wire
